// [design/cabp_regs.vh]
/*
 * constants of the asynchronous bus address/data port: variant codes,
 * state codes, strobe levels and field positions.
 * assumes inclusion by cabp_port.v only.
 */
`ifndef CABP_REGS_VH
`define CABP_REGS_VH

// ==================================================
// variants
`define CABP_VAR_WORD      2'h0
`define CABP_VAR_SELECT    2'h1
`define CABP_VAR_BYTE_SML  2'h2
`define CABP_VAR_BYTE_LRG  2'h3

// ==================================================
// address widths per variant, counted as top bit index
`define CABP_ATOP_WIDE     5'h17
`define CABP_ATOP_SML      5'h13
`define CABP_ATOP_LRG      5'h15

// ==================================================
// interrupt level field on the address lines
`define CABP_LVL_LSB       1
`define CABP_LVL_MSB       3

// ==================================================
// edges the width strap needs to cross its synchroniser
`define CABP_STRAP_WAIT    2'h2

// ==================================================
// one-hot states
`define CABP_S_IDLE        5'h01
`define CABP_S_ADDR        5'h02
`define CABP_S_ASRT        5'h04
`define CABP_S_WAIT        5'h08
`define CABP_S_TERM        5'h10

// ==================================================
// reset values of pins
`define CABP_STRB_NEG      1'h1
`define CABP_RW_READ       1'h1

`endif

// [design/cabp_port.v]
/*
 * cabp_port: address and data side of an asynchronous external bus master.
 * assumes a user that holds req until done pulses, a bus partner that
 * answers with transfer acknowledge, and a testbench resolving pin levels.
 */
// Function
// - drive three-state word address on 23 lines spanning 16 megabytes
// - present transfer address in all cycles except interrupt acknowledge
// - interrupt acknowledge: level on bits 1..3, higher lines driven high
// - 24-line variant drives bit 0 high during interrupt acknowledge
// - selectable variant in 16-bit mode holds address bit 0 high
// - byte-wide variant has 20-bit or 22-bit address
// - byte-wide acknowledge: level on bits 1..3, bit 0 and upper bits high
// - bidirectional three-state data bus, 16 or 8 bits, words or bytes
// - 8-bit mode moves data on low lanes only, upper lanes undefined
// - address-valid strobe asserted only while address is valid
// - read/write line marks each transfer as read or write
// - sequencing uses only strobes, read/write and transfer acknowledge
// - signals treated as asserted at active level, whatever polarity
// - 8-bit mode keeps upper strobe negated, lower strobe alone used
// - acknowledge latches read data and ends cycle; write just ends
`timescale 1ns/1ps
`include "cabp_regs.vh"

module cabp_port #(
	parameter [1:0] VARIANT = 2'h0
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire        ce,
	input  wire        req,
	input  wire        req_read,
	input  wire        req_byte,
	input  wire        req_iack,
	input  wire [2:0]  req_level,
	input  wire [23:0] req_addr,
	input  wire [15:0] req_wdata,
	output reg         done,
	output reg  [15:0] rdata,
	output reg         narrow_mode,
	input  wire        mode_wide_pin,
	output reg  [23:0] word_address_lines,
	output reg  [23:0] word_address_lines_oe,
	input  wire [15:0] data_lines_i,
	output reg  [15:0] data_lines_o,
	output reg  [15:0] data_lines_oe,
	output reg         address_valid_strobe_n,
	output reg         address_valid_strobe_oe,
	output reg         read_write,
	output reg         read_write_oe,
	output reg         upper_byte_strobe_n,
	output reg         upper_byte_strobe_oe,
	output reg         lower_byte_strobe_n,
	output reg         lower_byte_strobe_oe,
	input  wire        transfer_acknowledge_n
);

// ==================================================
// variant decode
	localparam [4:0] ATOP = (VARIANT == `CABP_VAR_BYTE_SML) ? `CABP_ATOP_SML :
	                        (VARIANT == `CABP_VAR_BYTE_LRG) ? `CABP_ATOP_LRG : `CABP_ATOP_WIDE;
	localparam       BYTE_WIDE = (VARIANT == `CABP_VAR_BYTE_SML) || (VARIANT == `CABP_VAR_BYTE_LRG);
	localparam       HAS_A0 = (VARIANT != `CABP_VAR_WORD);

	// lines that exist on this variant
	function [23:0] line_mask;
		input dummy;
		integer i;
		begin
			line_mask = 24'h000000;
			for (i = 0; i < 24; i = i + 1) begin
				if (i <= ATOP && (i != 0 || HAS_A0))
					line_mask[i] = 1'b1;
			end
		end
	endfunction

	localparam [23:0] LINES = line_mask(1'b0);
	localparam [15:0] DMASK = BYTE_WIDE ? 16'h00ff : 16'hffff;

// ==================================================
// pin synchronisers
	reg        ack_s1_q;
	reg        ack_s2_q;
	reg [15:0] din_s1_q;
	reg [15:0] din_s2_q;
	reg        mode_s1_q;
	reg        mode_s2_q;
	reg        strap_done_q;
	reg [1:0]  strap_cnt_q;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ack_s1_q  <= `CABP_STRB_NEG;
			ack_s2_q  <= `CABP_STRB_NEG;
			din_s1_q  <= 16'h0000;
			din_s2_q  <= 16'h0000;
			mode_s1_q <= 1'b1;
			mode_s2_q <= 1'b1;
		end else if (ce) begin
			ack_s1_q  <= transfer_acknowledge_n;
			ack_s2_q  <= ack_s1_q;
			din_s1_q  <= data_lines_i;
			din_s2_q  <= din_s1_q;
			mode_s1_q <= mode_wide_pin;
			mode_s2_q <= mode_s1_q;
		end
	end

	wire ack_seen = ~ack_s2_q;

	// width strap is caught once after release, changes later are ignored
	// the synchroniser leaves reset at its idle level, so wait until the pin has crossed it
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			strap_cnt_q  <= 2'h0;
			strap_done_q <= 1'b0;
			narrow_mode  <= 1'b0;
		end else if (ce && !strap_done_q) begin
			if (strap_cnt_q == `CABP_STRAP_WAIT) begin
				strap_done_q <= 1'b1;
				narrow_mode  <= (VARIANT == `CABP_VAR_SELECT) ? ~mode_s2_q : BYTE_WIDE;
			end else begin
				strap_cnt_q <= strap_cnt_q + 2'h1;
			end
		end
	end

// ==================================================
// cycle set-up
	wire        lanes8 = narrow_mode;
	wire        is_byte = req_byte | req_iack | lanes8;
	wire        cyc_read = req_read | req_iack;
	reg  [23:0] addr_d;
	reg  [15:0] wdat_d;
	reg         ustb_d;
	reg         lstb_d;

	always @* begin
		addr_d = req_addr & LINES;
		if (req_iack) begin
			addr_d = LINES;
			addr_d[`CABP_LVL_MSB:`CABP_LVL_LSB] = req_level;
		end
		if (VARIANT == `CABP_VAR_SELECT && !lanes8)
			addr_d[0] = 1'b1;
		if (lanes8)
			wdat_d = {8'h00, req_wdata[7:0]};
		else if (is_byte)
			wdat_d = {req_wdata[7:0], req_wdata[7:0]};
		else
			wdat_d = req_wdata;
		if (lanes8) begin
			ustb_d = 1'b0;
			lstb_d = 1'b1;
		end else if (is_byte && !req_iack) begin
			ustb_d = ~req_addr[0];
			lstb_d = req_addr[0];
		end else begin
			ustb_d = ~req_iack;
			lstb_d = 1'b1;
		end
	end

// ==================================================
// bus sequencer
	reg [4:0] state_q;
	reg       ustb_q;
	reg       lstb_q;
	reg       byte_q;
	reg       hi_q;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q                 <= `CABP_S_IDLE;
			done                    <= 1'b0;
			rdata                   <= 16'h0000;
			word_address_lines      <= 24'h000000;
			word_address_lines_oe   <= 24'h000000;
			data_lines_o            <= 16'h0000;
			data_lines_oe           <= 16'h0000;
			address_valid_strobe_n  <= `CABP_STRB_NEG;
			address_valid_strobe_oe <= 1'b0;
			read_write              <= `CABP_RW_READ;
			read_write_oe           <= 1'b0;
			upper_byte_strobe_n     <= `CABP_STRB_NEG;
			upper_byte_strobe_oe    <= 1'b0;
			lower_byte_strobe_n     <= `CABP_STRB_NEG;
			lower_byte_strobe_oe    <= 1'b0;
			ustb_q                  <= 1'b0;
			lstb_q                  <= 1'b0;
			byte_q                  <= 1'b0;
			hi_q                    <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			// sole master, so control and address lines are driven once out of reset, the upper strobe on the non-byte-wide variants only
			word_address_lines_oe   <= LINES;
			address_valid_strobe_oe <= 1'b1;
			read_write_oe           <= 1'b1;
			upper_byte_strobe_oe    <= ~BYTE_WIDE;
			lower_byte_strobe_oe    <= 1'b1;
			case (state_q)
				`CABP_S_IDLE: begin
					// wait for partner to release acknowledge
					if (req && strap_done_q && !ack_seen) begin
						word_address_lines <= addr_d;
						read_write         <= cyc_read;
						data_lines_o       <= wdat_d & DMASK;
						data_lines_oe      <= cyc_read ? 16'h0000 : (lanes8 ? 16'h00ff : 16'hffff) & DMASK;
						ustb_q             <= ustb_d & ~BYTE_WIDE;
						lstb_q             <= lstb_d;
						byte_q             <= is_byte;
						hi_q               <= ~lanes8 & is_byte & ~req_addr[0] & ~req_iack;
						state_q            <= `CABP_S_ADDR;
					end
				end
				`CABP_S_ADDR: begin
					address_valid_strobe_n <= 1'b0;
					state_q                <= `CABP_S_ASRT;
				end
				`CABP_S_ASRT: begin
					upper_byte_strobe_n <= ~ustb_q;
					lower_byte_strobe_n <= ~lstb_q;
					state_q             <= `CABP_S_WAIT;
				end
				`CABP_S_WAIT: begin
					if (ack_seen) begin
						if (read_write) begin
							if (!byte_q)
								rdata <= din_s2_q;
							else if (hi_q)
								rdata <= {8'h00, din_s2_q[15:8]};
							else
								rdata <= {8'h00, din_s2_q[7:0]};
						end
						address_valid_strobe_n <= `CABP_STRB_NEG;
						upper_byte_strobe_n    <= `CABP_STRB_NEG;
						lower_byte_strobe_n    <= `CABP_STRB_NEG;
						data_lines_oe          <= 16'h0000;
						done                   <= 1'b1;
						state_q                <= `CABP_S_TERM;
					end
				end
				`CABP_S_TERM: begin
					// one idle cycle with strobes negated before the next request
					state_q <= `CABP_S_IDLE;
				end
				default: begin
					state_q <= `CABP_S_IDLE;
				end
			endcase
		end
	end

endmodule // cabp_port

// [testbench/cabp_sva.sv]
/* pin checks for cabp_port, bound to every instance: variant 0 word bus and variant 1.
 * assumes a partner that holds acknowledge until the strobes rise. */
`timescale 1ns/1ps
module cabp_sva (
	input wire        mclk,
	input wire        rst,
	input wire        done,
	input wire [15:0] data_lines_o,
	input wire [15:0] data_lines_oe,
	input wire [23:0] word_address_lines,
	input wire [23:0] word_address_lines_oe,
	input wire        address_valid_strobe_n,
	input wire        read_write,
	input wire        upper_byte_strobe_n,
	input wire        lower_byte_strobe_n,
	input wire        transfer_acknowledge_n
);
	// ========
	// cycle shape
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_DONE_ENDS: assert property (done |-> address_valid_strobe_n && !$past(address_valid_strobe_n))
		else $error("done without strobe release");
	AST_ADDR_HOLD: assert property (!address_valid_strobe_n && !$past(address_valid_strobe_n) |->
		$stable(word_address_lines) && $stable(read_write)) else $error("address moved in cycle");
	AST_WDATA_HOLD: assert property (!address_valid_strobe_n && |data_lines_oe |-> $stable(data_lines_o))
		else $error("write data moved in cycle");
	AST_DRIVE_WRITE: assert property (|data_lines_oe |-> !read_write) else $error("data driven on read");
	AST_STROBE_SEQ: assert property ($fell(address_valid_strobe_n) |=> !upper_byte_strobe_n || !lower_byte_strobe_n)
		else $error("byte strobe late");
	AST_ACK_DONE: assert property ($fell(transfer_acknowledge_n) && !address_valid_strobe_n |-> ##[2:3] done)
		else $error("acknowledge not ending cycle");
	AST_ADDR_DRIVEN: assert property (!address_valid_strobe_n |-> &word_address_lines_oe[23:1])
		else $error("address not driven");
	AST_DONE_CAUSE: assert property (done |-> data_lines_oe == 16'h0 && !$past(transfer_acknowledge_n, 2))
		else $error("done without acknowledge");
endmodule // cabp_sva

bind cabp_port cabp_sva i_cabp_sva (.*);

// [testbench/cabp_mem.sv]
/* memory and interrupt responder on the far side of the bus.
 * assumes low addresses only; wait_cycles sets response speed. */
`timescale 1ns/1ps
module cabp_mem (
	input wire        mclk,
	input wire [3:0]  wait_cycles,
	input wire [23:0] addr,
	input wire [15:0] wdata,
	input wire        as_n,
	input wire        uds_n,
	input wire        lds_n,
	input wire        rw,
	output reg        ack_n,
	output reg [15:0] rd
);
	reg [15:0] mem_q [0:15];
	reg [4:0]  cnt_q;
	initial begin
		ack_n = 1'h1;
		rd = 16'h0;
		cnt_q = 5'h0;
	end
	// ========
	// responder
	always @(posedge mclk) begin
		if (as_n) begin
			ack_n <= 1'h1;
			cnt_q <= 5'h0;
			// released bus must not show a stale value
			rd <= ~rd;
		end else if (!uds_n || !lds_n) begin
			cnt_q <= cnt_q + 5'h1;
			if (cnt_q == 5'h0)
				rd <= &addr[23:4] ? {8'h0, 5'h3, addr[3:1]} : mem_q[addr[4:1]];
			if (!rw && !uds_n)
				mem_q[addr[4:1]][15:8] <= wdata[15:8];
			if (!rw && !lds_n)
				mem_q[addr[4:1]][7:0] <= wdata[7:0];
			if (cnt_q == {1'h0, wait_cycles} + 5'h2)
				ack_n <= 1'h0;
		end
	end
endmodule // cabp_mem

// [testbench/tb_top.sv]
/* self-checking bench for cabp_port, variant 0 and variant 1 strapped to 8-bit mode, run side by side.
 * assumes cabp_mem as bus partner and cabp_sva bound to the port. */
`timescale 1ns/1ps
module tb_top;
	reg         mclk, rst, req, req_read, req_byte, req_iack;
	reg [2:0]   req_level;
	reg [23:0]  req_addr;
	reg [15:0]  req_wdata;
	reg [3:0]   wait_cycles;
	reg         ub_s, lb_s, ub2_s;
	integer     bad_count, tests_run, cyc;
	wire        done, as_n, rw, ub_n, lb_n, ack_n;
	wire [15:0] rdata, d_o, d_oe, pd;
	wire [23:0] a, a_oe;
	wire [15:0] d_i = (d_oe & d_o) | (~d_oe & pd);
	wire        nm, nm2, as_oe, rw_oe, ub_oe, lb_oe;
	wire        done2, as2_n, rw2, ub2_n, lb2_n, ack2_n;
	wire [15:0] rdata2, d2_o, d2_oe, pd2;
	wire [23:0] a2, a2_oe;
	wire [15:0] d2_i = (d2_oe & d2_o) | (~d2_oe & pd2);
	cabp_port #(.VARIANT(2'h0)) i_cabp_port (.mclk(mclk), .rst(rst), .ce(1'h1), .req(req),
		.req_read(req_read), .req_byte(req_byte), .req_iack(req_iack), .req_level(req_level),
		.req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rdata(rdata), .narrow_mode(nm),
		.mode_wide_pin(1'h1), .word_address_lines(a), .word_address_lines_oe(a_oe),
		.data_lines_i(d_i), .data_lines_o(d_o), .data_lines_oe(d_oe), .address_valid_strobe_n(as_n),
		.address_valid_strobe_oe(as_oe), .read_write(rw), .read_write_oe(rw_oe), .upper_byte_strobe_n(ub_n),
		.upper_byte_strobe_oe(ub_oe), .lower_byte_strobe_n(lb_n), .lower_byte_strobe_oe(lb_oe),
		.transfer_acknowledge_n(ack_n));
	cabp_mem i_cabp_mem (.mclk(mclk), .wait_cycles(wait_cycles), .addr(a), .wdata(d_o), .as_n(as_n),
		.uds_n(ub_n), .lds_n(lb_n), .rw(rw), .ack_n(ack_n), .rd(pd));
	// selectable-width variant with the strap low: every transfer is one byte on the low lanes
	cabp_port #(.VARIANT(2'h1)) i_cabp_port_narrow (.mclk(mclk), .rst(rst), .ce(1'h1), .req(req),
		.req_read(req_read), .req_byte(req_byte), .req_iack(req_iack), .req_level(req_level),
		.req_addr(req_addr), .req_wdata(req_wdata), .done(done2), .rdata(rdata2), .narrow_mode(nm2),
		.mode_wide_pin(1'h0), .word_address_lines(a2), .word_address_lines_oe(a2_oe),
		.data_lines_i(d2_i), .data_lines_o(d2_o), .data_lines_oe(d2_oe), .address_valid_strobe_n(as2_n),
		.address_valid_strobe_oe(), .read_write(rw2), .read_write_oe(), .upper_byte_strobe_n(ub2_n),
		.upper_byte_strobe_oe(), .lower_byte_strobe_n(lb2_n), .lower_byte_strobe_oe(),
		.transfer_acknowledge_n(ack2_n));
	cabp_mem i_cabp_mem_narrow (.mclk(mclk), .wait_cycles(wait_cycles), .addr(a2), .wdata(d2_o),
		.as_n(as2_n), .uds_n(ub2_n), .lds_n(lb2_n), .rw(rw2), .ack_n(ack2_n), .rd(pd2));
	initial begin
		mclk = 1'h0;
		forever #12.5 mclk = ~mclk;
	end
	// ========
	// helpers
	task check(input [63:0] nm, input [23:0] seen, input [23:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				bad_count = bad_count + 1;
				$display("unexpected %0s exp %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task give_verdict;
		begin
			if (bad_count == 0 && tests_run > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// holds req until done, noting which byte strobes fell
	task bus(input r, input b, input k, input [2:0] l, input [23:0] ad, input [15:0] w);
		integer n;
		begin
			@(posedge mclk) #1;
			{req, req_read, req_byte, req_iack, req_level, req_addr, req_wdata} = {1'h1, r, b, k, l, ad, w};
			{ub_s, lb_s} = 2'h0;
			for (n = 0; n < 40 && done !== 1'h1; n = n + 1) begin
				@(posedge mclk) #1;
				ub_s = ub_s | !ub_n;
				lb_s = lb_s | !lb_n;
				ub2_s = ub2_s | !ub2_n;
			end
			check("done", done, 24'h1);
			check("done2", done2, 24'h1);
			req = 1'h0;
			repeat (2) @(posedge mclk);
		end
	endtask
	// ========
	// scenarios
	task t_word;
		begin
			bus(1'h0, 1'h0, 1'h0, 3'h0, 24'h10, 16'h1234);
			check("addr", a[23:1], 24'h8);
			check("rw", rw, 24'h0);
			check("strobes", {ub_s, lb_s}, 24'h3);
			check("d2_o", d2_o, 24'h34);
			check("addr2", a2, 24'h10);
			wait_cycles = 4'h5;
			bus(1'h1, 1'h0, 1'h0, 3'h0, 24'h10, 16'h0);
			check("rdata", rdata, 24'h1234);
			check("rw", rw, 24'h1);
			check("addr_oe", a_oe, 24'hfffffe);
			check("rdata2", rdata2, 24'h34);
			check("addr2_oe", a2_oe, 24'hffffff);
			check("modes", {nm, nm2}, 24'h1);
			check("ctl_oe", {as_oe, rw_oe, ub_oe, lb_oe}, 24'hf);
			wait_cycles = 4'h0;
		end
	endtask
	task t_bytes;
		begin
			bus(1'h0, 1'h1, 1'h0, 3'h0, 24'h21, 16'h00ab);
			check("strobes", {ub_s, lb_s}, 24'h1);
			bus(1'h0, 1'h1, 1'h0, 3'h0, 24'h20, 16'h00cd);
			check("strobes", {ub_s, lb_s}, 24'h2);
			bus(1'h1, 1'h0, 1'h0, 3'h0, 24'h20, 16'h0);
			check("rdata", rdata, 24'hcdab);
			check("rdata2", rdata2, 24'hcd);
			bus(1'h1, 1'h1, 1'h0, 3'h0, 24'h20, 16'h0);
			check("rdata", rdata, 24'h00cd);
		end
	endtask
	task t_iack;
		integer i;
		begin
			for (i = 1; i < 8; i = i + 1) begin
				bus(1'h1, 1'h1, 1'h1, i[2:0], 24'h0, 16'h0);
				check("iackaddr", a[23:1], {4'h7, 17'h1ffff, i[2:0]});
				check("vector", rdata, {8'h0, 5'h3, i[2:0]});
				check("strobes", {ub_s, lb_s}, 24'h1);
				check("iack2", a2, {20'hfffff, i[2:0], 1'h1});
				check("vector2", rdata2, {8'h0, 5'h3, i[2:0]});
			end
		end
	endtask
	// ========
	// main
	always @(posedge mclk) begin
		cyc = cyc + 1;
		// a hung handshake must still reach the report
		if (cyc == 5000) begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end
	initial begin
		{rst, req, req_read, req_byte, req_iack, req_level, req_addr, req_wdata} = {1'h1, 47'h0};
		{wait_cycles, bad_count, tests_run, cyc} = {4'h0, 96'h0};
		ub2_s = 1'h0;
		repeat (3) @(posedge mclk);
		check("idle", {d_oe, as_n}, 24'h1);
		#1 rst = 1'h0;
		repeat (3) @(posedge mclk);
		t_word;
		t_bytes;
		t_iack;
		check("ub2_s", ub2_s, 24'h0);
		give_verdict;
	end
endmodule // tb_top
